// File: sim/input_voltage_fault_supervisor_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", what, exp, got); end end
module input_voltage_fault_supervisor_test;
    // Short retry step keeps the hold-off sequences brief
    localparam int T = 10;
    logic        clock_i = 1'h0;
    logic        rstn_i = 1'h0;
    logic        output_enable_i = 1'h1;
    logic        clear_faults_i = 1'h0;
    logic        vin_ov_fault_i = 1'h0;
    logic        vin_ov_warn_i = 1'h0;
    logic        vin_uv_warn_i = 1'h0;
    logic [7:0]  cmd_code;
    logic        wr_en;
    logic        rd_en;
    logic [15:0] wr_data;
    logic [15:0] rd_data_o;
    logic        cmd_hit_o;
    logic [15:0] ov_fault_limit_o;
    logic [15:0] ov_warn_limit_o;
    logic [15:0] uv_warn_limit_o;
    logic        output_on_o;
    logic        status_ov_fault_o;
    logic        status_ov_warn_o;
    logic        status_uv_warn_o;
    logic        alert_line_n_o;
    logic        alert_line_n_oe_o;
    int          errors = 0;
    int          checked = 0;
    int          cycles = 0;
    logic [7:0]  codes [4] = '{8'h55, 8'h56, 8'h57, 8'h58};
    logic [15:0] rst_v [4] = '{16'h0000, 16'h0080, 16'h0000, 16'h0000};
    logic [15:0] wr_v [4] = '{16'hA5C3, 16'h12B7, 16'h7E01, 16'hC018};
    logic [15:0] exp_v [4] = '{16'hA5C3, 16'h00B7, 16'h7E01, 16'hC018};
    int          rc [4] = '{0, 2, 6, 7};
    int          dl [3] = '{0, 3, 7};
    int          md [3] = '{0, 1, 3};

    ivfs_supervisor #(.RETRY_STEP_CYCLES(T)) dut_u (
        .clock_i(clock_i), .rstn_i(rstn_i), .cmd_code_i(cmd_code), .wr_en_i(wr_en),
        .wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data_o), .cmd_hit_o(cmd_hit_o),
        .output_enable_i(output_enable_i), .clear_faults_i(clear_faults_i),
        .vin_ov_fault_i(vin_ov_fault_i), .vin_ov_warn_i(vin_ov_warn_i),
        .vin_uv_warn_i(vin_uv_warn_i), .ov_fault_limit_o(ov_fault_limit_o),
        .ov_warn_limit_o(ov_warn_limit_o), .uv_warn_limit_o(uv_warn_limit_o),
        .output_on_o(output_on_o), .status_ov_fault_o(status_ov_fault_o),
        .status_ov_warn_o(status_ov_warn_o), .status_uv_warn_o(status_uv_warn_o),
        .alert_line_n_o(alert_line_n_o), .alert_line_n_oe_o(alert_line_n_oe_o));

    ivfs_host_model host_u (
        .clock_i(clock_i), .rd_data_i(rd_data_o), .cmd_code_o(cmd_code),
        .wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en));

    // ****************************************************************
    // Clock, watchdog and verdict
    // ****************************************************************
    always #20 clock_i = ~clock_i;

    // Whole run needs about a thousand cycles; a hang is stopped at the 20000-cycle limit, far above that
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic clear_all();
        clear_faults_i = 1'h1;
        step(1);
        clear_faults_i = 1'h0;
        step(1);
    endtask

    task automatic fault_pulse();
        vin_ov_fault_i = 1'h1;
        step(1);
        vin_ov_fault_i = 1'h0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [15:0] d;
        int          n;
        int          ups;
        logic        prev;
        step(8);
        rstn_i = 1'h1;
        // Reset contents, then write and read back every register
        for (int i = 0; i < 4; i++) begin
            host_u.read_reg(codes[i], d);
            `CHK("reset value", rst_v[i], d)
            host_u.write_reg(codes[i], wr_v[i]);
            host_u.read_reg(codes[i], d);
            `CHK("read back", exp_v[i], d)
            `CHK("code hit", 1'h1, cmd_hit_o)
        end
        `CHK("fault limit out", 16'hA5C3, ov_fault_limit_o)
        `CHK("ov warn limit out", 16'h7E01, ov_warn_limit_o)
        `CHK("uv warn limit out", 16'hC018, uv_warn_limit_o)
        // Unmapped code neither stores nor answers
        host_u.write_reg(8'h59, 16'hFFFF);
        host_u.read_reg(8'h59, d);
        `CHK("unmapped read", 16'h0000, d)
        `CHK("unmapped hit", 1'h0, cmd_hit_o)
        // Warnings flag and alert but leave the output running
        for (int k = 0; k < 2; k++) begin
            vin_ov_warn_i = (k == 0);
            vin_uv_warn_i = (k == 1);
            step(1);
            vin_ov_warn_i = 1'h0;
            vin_uv_warn_i = 1'h0;
            step(1);
            `CHK("warn flag", 1'h1, k == 0 ? status_ov_warn_o : status_uv_warn_o)
            `CHK("warn alert", 1'h1, alert_line_n_oe_o)
            `CHK("alert level", 1'h0, alert_line_n_o)
            `CHK("on during warn", 1'h1, output_on_o)
            clear_all();
            `CHK("alert released", 1'h0, alert_line_n_oe_o)
        end
        // Modes other than disable-and-retry only flag and alert
        for (int k = 0; k < 3; k++) begin
            host_u.write_reg(codes[1], {8'h00, md[k][1:0], 6'h08});
            fault_pulse();
            step(2);
            `CHK("on in flag mode", 1'h1, output_on_o)
            `CHK("fault flag", 1'h1, status_ov_fault_o)
            `CHK("fault alert", 1'h1, alert_line_n_oe_o)
            clear_all();
        end
        // One retry after a brief fault; off time follows the delay field
        for (int k = 0; k < 3; k++) begin
            host_u.write_reg(codes[1], 16'h0088 | 16'(dl[k]));
            fault_pulse();
            n = 0;
            do begin
                step(1);
                n++;
            end while (output_on_o !== 1'h1 && n < 1000);
            `CHK("off cycles", (dl[k] + 1) * T, n)
            `CHK("fault flag", 1'h1, status_ov_fault_o)
            clear_all();
        end
        // Persistent fault: count restarts for none, some, most and endless
        for (int k = 0; k < 4; k++) begin
            host_u.write_reg(codes[1], 16'h0080 | 16'(rc[k] << 3));
            vin_ov_fault_i = 1'h1;
            ups = 0;
            repeat (200) begin
                prev = output_on_o;
                step(1);
                if (prev === 1'h0 && output_on_o === 1'h1) ups++;
            end
            if (rc[k] == 7) begin
                `CHK("endless retry", 1'h1, ups > 6)
            end else begin
                `CHK("restarts", rc[k], ups)
            end
            // Disabling the output ends endless retry even with the fault present
            if (rc[k] == 7) begin
                output_enable_i = 1'h0;
                step(2);
                `CHK("off when disabled", 1'h0, output_on_o)
                output_enable_i = 1'h1;
            end
            vin_ov_fault_i = 1'h0;
            step(1);
            clear_all();
            step(2);
            `CHK("on after clear", 1'h1, output_on_o)
            `CHK("flag cleared", 1'h0, status_ov_fault_o)
        end
        end_sim();
    end
endmodule
`default_nettype wire

// File: sim/ivfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host side of the register port
// ****************************************************************
module ivfs_host_model (
    input  wire logic        clock_i,
    input  wire logic [15:0] rd_data_i,
    output var logic [7:0]   cmd_code_o,
    output var logic         wr_en_o,
    output var logic [15:0]  wr_data_o,
    output var logic         rd_en_o
);
    // Idle bus from time zero
    initial begin
        cmd_code_o = 8'h00;
        wr_en_o    = 1'h0;
        wr_data_o  = 16'h0000;
        rd_en_o    = 1'h0;
    end

    // One write; code and data held until the strobe edge has passed
    task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
        @(posedge clock_i);
        #1;
        cmd_code_o = code;
        wr_data_o  = data;
        wr_en_o    = 1'h1;
        @(posedge clock_i);
        #1;
        wr_en_o   = 1'h0;
        wr_data_o = ~data; // Stale data must not pass for valid
    endtask

    // One read; data taken after the capture edge has settled
    task automatic read_reg(input logic [7:0] code, output logic [15:0] data);
        @(posedge clock_i);
        #1;
        cmd_code_o = code;
        rd_en_o    = 1'h1;
        @(posedge clock_i);
        #1;
        rd_en_o = 1'h0;
        data    = rd_data_i;
    endtask
endmodule
`default_nettype wire

// File: verilog/ivfs_pkg.sv
`default_nettype none
package ivfs_pkg;
    // ****************************************************************
    // Command codes
    // ****************************************************************
    localparam logic [7:0] CMD_OV_FAULT_LIMIT  = 8'h55;
    localparam logic [7:0] CMD_OV_FAULT_ACTION = 8'h56;
    localparam logic [7:0] CMD_OV_WARN_LIMIT   = 8'h57;
    localparam logic [7:0] CMD_UV_WARN_LIMIT   = 8'h58;

    // ****************************************************************
    // Fault action byte layout
    // ****************************************************************
    localparam int         RESP_MSB           = 7;
    localparam int         RESP_LSB           = 6;
    localparam int         RETRY_MSB          = 5;
    localparam int         RETRY_LSB          = 3;
    localparam int         DELAY_MSB          = 2;
    localparam int         DELAY_LSB          = 0;
    localparam logic [1:0] RESP_DISABLE_RETRY = 2'h2;
    localparam logic [2:0] RETRY_NONE         = 3'h0;
    localparam logic [2:0] RETRY_FOREVER      = 3'h7;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] RST_OV_FAULT_LIMIT  = 16'h0000;
    localparam logic [7:0]  RST_OV_FAULT_ACTION = 8'h80;
    localparam logic [15:0] RST_OV_WARN_LIMIT   = 16'h0000;
    localparam logic [15:0] RST_UV_WARN_LIMIT   = 16'h0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLOCK_HZ          = 25_000_000;
    localparam int unsigned RETRY_STEP_MS     = 35;
    localparam int unsigned RETRY_STEP_CYCLES = CLOCK_HZ / 1000 * RETRY_STEP_MS;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RUN,
        ST_HOLD_OFF,
        ST_LATCHED
    } ivfs_state_t;
endpackage
`default_nettype wire

// File: verilog/ivfs_retry_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ivfs_retry_timer #(
    parameter int unsigned TICK_CYCLES = ivfs_pkg::RETRY_STEP_CYCLES
) (
    input  wire logic       clock_i,
    input  wire logic       rstn_i,
    input  wire logic       start_i,
    input  wire logic [2:0] delay_sel_i,
    output logic            busy_o,
    output logic            done_o
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    logic [CW-1:0] div_q;
    logic [2:0]    step_q;
    logic [2:0]    sel_q;
    logic          run_q;
    logic          tick;
    logic [31:0]   elapsed_q;

    // ****************************************************************
    // Step divider
    // ****************************************************************
    // One step is one tick of the divider
    assign tick   = run_q && (div_q == CW'(TICK_CYCLES - 1));
    assign done_o = tick && (step_q == sel_q); // R8
    assign busy_o = run_q;

    // Divider restarts with every start so steps stay whole
    always_ff @(posedge clock_i) begin
        if (!rstn_i || start_i || !run_q || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + CW'(1);
        end
    end

    // Step count and delay selection, latched at start
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            step_q <= 3'h0;
            sel_q  <= 3'h0;
        end else if (start_i) begin
            step_q <= 3'h0;
            sel_q  <= delay_sel_i; // R8
        end else if (tick) begin
            step_q <= step_q + 3'h1;
        end
    end

    // Run flag
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            run_q <= 1'b0;
        end else if (start_i) begin
            run_q <= 1'b1;
        end else if (done_o) begin
            run_q <= 1'b0;
        end
    end

    // Helper count for the delay check only
    always_ff @(posedge clock_i) begin
        if (!rstn_i || start_i) begin
            elapsed_q <= 32'h0;
        end else if (run_q) begin
            elapsed_q <= elapsed_q + 32'h1;
        end
    end

    a_delay_length: assert property (@(posedge clock_i) disable iff (!rstn_i) // R8
        done_o |-> elapsed_q == (32'(sel_q) + 32'h1) * 32'(TICK_CYCLES) - 32'h1)
        else $error("retry delay length wrong");
endmodule
`default_nettype wire

// File: verilog/ivfs_supervisor.sv
// Behaviour
// (R1) Over-voltage fault limit, 16-bit read/write word at code 0x55.
// (R2) Fault action byte at 0x56 with response, retry count, retry delay fields.
// (R3) Response 10 turns output off at once on fault, then retries.
// (R4) Any fault sets the fault flag and pulls the alert line low.
// (R5) Retry count field sets number of restart attempts after shutdown.
// (R6) Retry count 000 means no restart; output stays off until cleared.
// (R7) Retry count 111 retries forever until disabled or reset.
// (R8) Delay between attempts is (field plus one) times 35 ms.
// (R9) Over-voltage warning limit, 16-bit read/write word at code 0x57.
// (R10) Under-voltage warning limit, 16-bit read/write word at code 0x58.
// (R11) Warnings set their flag and alert, output stays on.
`timescale 1ns/1ps
`default_nettype none
module ivfs_supervisor #(
    parameter int unsigned RETRY_STEP_CYCLES = ivfs_pkg::RETRY_STEP_CYCLES
) (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic        wr_en_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        rd_en_i,
    output logic [15:0]      rd_data_o,
    output logic             cmd_hit_o,
    input  wire logic        output_enable_i,
    input  wire logic        clear_faults_i,
    input  wire logic        vin_ov_fault_i,
    input  wire logic        vin_ov_warn_i,
    input  wire logic        vin_uv_warn_i,
    output logic [15:0]      ov_fault_limit_o,
    output logic [15:0]      ov_warn_limit_o,
    output logic [15:0]      uv_warn_limit_o,
    output logic             output_on_o,
    output logic             status_ov_fault_o,
    output logic             status_ov_warn_o,
    output logic             status_uv_warn_o,
    output logic             alert_line_n_o,
    output logic             alert_line_n_oe_o
);
    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [15:0] input_overvoltage_fault_limit_q;
    logic [7:0]  input_overvoltage_fault_action_q;
    logic [15:0] input_overvoltage_warning_limit_q;
    logic [15:0] input_undervoltage_warning_limit_q;
    logic [1:0]  resp_mode;
    logic [2:0]  retry_limit;
    logic [2:0]  retry_delay;

    assign resp_mode   = input_overvoltage_fault_action_q[ivfs_pkg::RESP_MSB:ivfs_pkg::RESP_LSB];
    assign retry_limit =
        input_overvoltage_fault_action_q[ivfs_pkg::RETRY_MSB:ivfs_pkg::RETRY_LSB];
    assign retry_delay =
        input_overvoltage_fault_action_q[ivfs_pkg::DELAY_MSB:ivfs_pkg::DELAY_LSB];

    // Word writes take all 16 bits, the action byte only the low byte
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            input_overvoltage_fault_limit_q    <= ivfs_pkg::RST_OV_FAULT_LIMIT;
            input_overvoltage_fault_action_q   <= ivfs_pkg::RST_OV_FAULT_ACTION;
            input_overvoltage_warning_limit_q  <= ivfs_pkg::RST_OV_WARN_LIMIT;
            input_undervoltage_warning_limit_q <= ivfs_pkg::RST_UV_WARN_LIMIT;
        end else if (wr_en_i) begin
            unique case (cmd_code_i)
                ivfs_pkg::CMD_OV_FAULT_LIMIT:  input_overvoltage_fault_limit_q <= wr_data_i; // R1
                ivfs_pkg::CMD_OV_FAULT_ACTION: input_overvoltage_fault_action_q <= wr_data_i[7:0]; // R2
                ivfs_pkg::CMD_OV_WARN_LIMIT:   input_overvoltage_warning_limit_q <= wr_data_i; // R9
                ivfs_pkg::CMD_UV_WARN_LIMIT:   input_undervoltage_warning_limit_q <= wr_data_i; // R10
                default: ;
            endcase
        end
    end

    // Combinational hit so the bus engine can refuse unknown codes
    always_comb begin
        cmd_hit_o = (cmd_code_i == ivfs_pkg::CMD_OV_FAULT_LIMIT)  ||
                    (cmd_code_i == ivfs_pkg::CMD_OV_FAULT_ACTION) ||
                    (cmd_code_i == ivfs_pkg::CMD_OV_WARN_LIMIT)   ||
                    (cmd_code_i == ivfs_pkg::CMD_UV_WARN_LIMIT);
    end

    // Read data registered; unknown codes read as zero
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_en_i) begin
            unique case (cmd_code_i)
                ivfs_pkg::CMD_OV_FAULT_LIMIT:  rd_data_o <= input_overvoltage_fault_limit_q; // R1
                ivfs_pkg::CMD_OV_FAULT_ACTION: rd_data_o <= {8'h00, input_overvoltage_fault_action_q};
                ivfs_pkg::CMD_OV_WARN_LIMIT:   rd_data_o <= input_overvoltage_warning_limit_q; // R9
                ivfs_pkg::CMD_UV_WARN_LIMIT:   rd_data_o <= input_undervoltage_warning_limit_q; // R10
                default:                       rd_data_o <= 16'h0000;
            endcase
        end
    end

    assign ov_fault_limit_o = input_overvoltage_fault_limit_q;
    assign ov_warn_limit_o  = input_overvoltage_warning_limit_q;
    assign uv_warn_limit_o  = input_undervoltage_warning_limit_q;

    // ****************************************************************
    // Fault response sequencer
    // ****************************************************************
    ivfs_pkg::ivfs_state_t state_q;
    ivfs_pkg::ivfs_state_t state_d;
    logic [2:0]            attempts_q;
    logic                  release_all;
    logic                  trip;
    logic                  timer_start;
    logic                  timer_done;
    logic                  retry_spent;

    // Disabling the output or clearing faults rearms the state, attempt count and retry timer
    assign release_all = clear_faults_i || !output_enable_i; // R6 R7
    assign trip        = (state_q == ivfs_pkg::ST_RUN) && vin_ov_fault_i && output_enable_i &&
                         (resp_mode == ivfs_pkg::RESP_DISABLE_RETRY); // R3
    // Unlimited mode never runs out of attempts
    assign retry_spent = (retry_limit == ivfs_pkg::RETRY_NONE) ||
                         ((retry_limit != ivfs_pkg::RETRY_FOREVER) &&
                          (attempts_q >= retry_limit)); // R5 R6 R7
    assign timer_start = !release_all && trip && !retry_spent;

    always_comb begin
        state_d = state_q;
        if (release_all) begin
            state_d = ivfs_pkg::ST_RUN;
        end else begin
            unique case (state_q)
                ivfs_pkg::ST_RUN: begin
                    if (trip) begin
                        state_d = retry_spent ? ivfs_pkg::ST_LATCHED
                                              : ivfs_pkg::ST_HOLD_OFF; // R3 R6
                    end
                end
                ivfs_pkg::ST_HOLD_OFF: begin
                    if (timer_done) begin
                        state_d = ivfs_pkg::ST_RUN; // R5 R7
                    end
                end
                ivfs_pkg::ST_LATCHED: state_d = ivfs_pkg::ST_LATCHED; // R6
                default:              state_d = ivfs_pkg::ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state_q <= ivfs_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // Attempts count restarts; saturates at 7 so forever mode cannot wrap
    always_ff @(posedge clock_i) begin
        if (!rstn_i || release_all) begin
            attempts_q <= 3'h0;
        end else if ((state_q == ivfs_pkg::ST_HOLD_OFF) && timer_done &&
                     (attempts_q != 3'h7)) begin
            attempts_q <= attempts_q + 3'h1; // R5
        end
    end

    // Output drops in the cycle after the fault is seen
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            output_on_o <= 1'b0;
        end else begin
            output_on_o <= output_enable_i && (state_d == ivfs_pkg::ST_RUN); // R3 R11
        end
    end

    ivfs_retry_timer #(
        .TICK_CYCLES (RETRY_STEP_CYCLES)
    ) u_timer (
        .clock_i     (clock_i),
        .rstn_i      (rstn_i && !release_all),
        .start_i     (timer_start),
        .delay_sel_i (retry_delay),
        .busy_o      (),
        .done_o      (timer_done)
    );

    // ****************************************************************
    // Status flags and alert
    // ****************************************************************
    // Sticky flags; a new event beats a clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            status_ov_fault_o <= 1'b0;
            status_ov_warn_o  <= 1'b0;
            status_uv_warn_o  <= 1'b0;
        end else begin
            status_ov_fault_o <= vin_ov_fault_i || (status_ov_fault_o && !clear_faults_i); // R4
            status_ov_warn_o  <= vin_ov_warn_i || (status_ov_warn_o && !clear_faults_i); // R11
            status_uv_warn_o  <= vin_uv_warn_i || (status_uv_warn_o && !clear_faults_i); // R11
        end
    end

    // Open drain: only ever pulls low, enable registered from the events and sticky flags, one cycle after the event
    assign alert_line_n_o = 1'b0;
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            alert_line_n_oe_o <= 1'b0;
        end else begin
            alert_line_n_oe_o <= vin_ov_fault_i || vin_ov_warn_i || vin_uv_warn_i ||
                ((status_ov_fault_o || status_ov_warn_o || status_uv_warn_o) &&
                 !clear_faults_i); // R4 R11
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_fault_limit_rw: assert property (@(posedge clock_i) disable iff (!rstn_i) // R1
        wr_en_i && cmd_code_i == ivfs_pkg::CMD_OV_FAULT_LIMIT
        |=> ov_fault_limit_o == $past(wr_data_i))
        else $error("fault limit write lost");
    a_action_rw: assert property (@(posedge clock_i) disable iff (!rstn_i) // R2
        wr_en_i && cmd_code_i == ivfs_pkg::CMD_OV_FAULT_ACTION ##1 !wr_en_i ##1 rd_en_i &&
        cmd_code_i == ivfs_pkg::CMD_OV_FAULT_ACTION && !wr_en_i
        |=> rd_data_o == {8'h00, $past(wr_data_i[7:0], 3)})
        else $error("action byte readback wrong");
    a_fault_turns_off: assert property (@(posedge clock_i) disable iff (!rstn_i) // R3
        trip && !release_all |=> !output_on_o && state_q != ivfs_pkg::ST_RUN)
        else $error("output not off after fault");
    a_fault_alerts: assert property (@(posedge clock_i) disable iff (!rstn_i) // R4
        vin_ov_fault_i |=> status_ov_fault_o && alert_line_n_oe_o && !alert_line_n_o)
        else $error("fault did not flag or alert");
    a_retry_bound: assert property (@(posedge clock_i) disable iff (!rstn_i) // R5
        retry_limit != ivfs_pkg::RETRY_FOREVER && $stable(retry_limit) &&
        state_q == ivfs_pkg::ST_HOLD_OFF |-> attempts_q < retry_limit)
        else $error("too many restart attempts");
    a_no_retry_hold: assert property (@(posedge clock_i) disable iff (!rstn_i) // R6
        state_q == ivfs_pkg::ST_LATCHED && !release_all |=> !output_on_o &&
        state_q == ivfs_pkg::ST_LATCHED)
        else $error("latched output restarted");
    a_forever_retry: assert property (@(posedge clock_i) disable iff (!rstn_i) // R7
        trip && !release_all && retry_limit == ivfs_pkg::RETRY_FOREVER
        |=> state_q == ivfs_pkg::ST_HOLD_OFF)
        else $error("unlimited retry stopped");
    a_restart_on_done: assert property (@(posedge clock_i) disable iff (!rstn_i) // R8
        state_q == ivfs_pkg::ST_HOLD_OFF && timer_done && output_enable_i && !clear_faults_i
        |=> output_on_o)
        else $error("no restart after delay");
    a_ov_warn_rw: assert property (@(posedge clock_i) disable iff (!rstn_i) // R9
        wr_en_i && cmd_code_i == ivfs_pkg::CMD_OV_WARN_LIMIT
        |=> ov_warn_limit_o == $past(wr_data_i))
        else $error("ov warning limit write lost");
    a_uv_warn_rw: assert property (@(posedge clock_i) disable iff (!rstn_i) // R10
        wr_en_i && cmd_code_i == ivfs_pkg::CMD_UV_WARN_LIMIT
        |=> uv_warn_limit_o == $past(wr_data_i))
        else $error("uv warning limit write lost");
    a_warn_keeps_on: assert property (@(posedge clock_i) disable iff (!rstn_i) // R11
        (vin_ov_warn_i || vin_uv_warn_i) && !vin_ov_fault_i && output_on_o &&
        state_q == ivfs_pkg::ST_RUN && output_enable_i
        |=> output_on_o && alert_line_n_oe_o)
        else $error("warning disturbed output or alert");
endmodule
`default_nettype wire
